// File: logic/agr_config_bank.sv
// Configuration bank: gain, data-rate and reference registers, their
// decoded outputs, and the programmable delay before the first conversion.
// Assumes the serial front end turns a register-write command into a
// one-cycle write strobe and i_mod_tick pulses once per modulator period.
//
// Overview of operation
// - Write restarts conversion after 14/25/64/256/1024/2048/4096 modulator periods by code.
// - Amplifier field 00 bypasses and powers down, 01 enables, others reserved.
// - Gain code 000..111 maps to gain 1,2,4,...,128; reset gives 1.
// - Chop bit set swaps inputs and averages two readings; resets off.
// - Clock bit 0 uses internal oscillator, 1 uses external clock.
// - Mode bit 0 converts continuously, 1 converts single-shot.
// - Filter bit 0 selects sinc-cubed, 1 low-latency; resets to 1.
// - Four-bit rate field selects 2.5 to 1000 samples per second.
// - Monitor field selects off, low, both, or low with pull-together.
// - Source field picks external pair 0, pair 1, or internal reference.
// - Internal reference field: off, on except power-down, or always on.
`timescale 1ns/1ns
`default_nettype none

module agr_config_bank (
   input  wire logic             i_clk,
   input  wire logic             i_arst_n,
   input  wire logic             i_ce,
   input  wire logic             i_wr_valid,
   input  wire logic [7:0]       i_wr_addr,
   input  wire logic [7:0]       i_wr_data,
   input  wire logic [7:0]       i_rd_addr,
   input  wire logic             i_mod_tick,
   output logic      [7:0]       o_rd_data,
   output agr_pkg::agr_cfg_t     o_cfg,
   output logic                  o_delay_busy,
   output logic                  o_conv_start
);

   // ---------------------------------------------------------------
   // Register write decode
   // ---------------------------------------------------------------
   logic [7:0] gain_q;
   logic [7:0] rate_q;
   logic [7:0] ref_q;
   wire        wr_gain = i_wr_valid && (i_wr_addr == agr_pkg::OFS_AMPLIFIER_GAIN_CONFIG);
   wire        wr_rate = i_wr_valid && (i_wr_addr == agr_pkg::OFS_CONVERSION_RATE_CONFIG);
   wire        wr_ref  = i_wr_valid && (i_wr_addr == agr_pkg::OFS_REFERENCE_CONFIG);
   wire        wr_any  = wr_gain || wr_rate || wr_ref;

   // Reserved codes are stored as written; the host keeps them out
   // stored verbatim
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         gain_q <= agr_pkg::RST_AMPLIFIER_GAIN_CONFIG;
         rate_q <= agr_pkg::RST_CONVERSION_RATE_CONFIG;
         ref_q  <= agr_pkg::RST_REFERENCE_CONFIG;
      end else if (i_ce) begin
         if (wr_gain) gain_q <= i_wr_data;
         if (wr_rate) rate_q <= i_wr_data;
         if (wr_ref)  ref_q  <= i_wr_data;
      end
   end

   // ---------------------------------------------------------------
   // Read path: unmapped offsets read as zero
   // ---------------------------------------------------------------
   wire [7:0] rd_d = (i_rd_addr == agr_pkg::OFS_AMPLIFIER_GAIN_CONFIG)  ? gain_q :
                     (i_rd_addr == agr_pkg::OFS_CONVERSION_RATE_CONFIG) ? rate_q :
                     (i_rd_addr == agr_pkg::OFS_REFERENCE_CONFIG)       ? ref_q  : 8'h00;

   // ---------------------------------------------------------------
   // Field decode
   // ---------------------------------------------------------------
   wire [1:0] amp_code = gain_q[agr_pkg::GAIN_AMP_LSB +: 2];
   wire [2:0] gain_code = gain_q[agr_pkg::GAIN_CODE_LSB +: 3];
   wire [1:0] mon_code = ref_q[agr_pkg::REF_MON_LSB +: 2];
   wire [1:0] con_code = ref_q[agr_pkg::REF_CON_LSB +: 2];
   wire [3:0] rate_code = rate_q[agr_pkg::RATE_SEL_LSB +: 4];
   agr_pkg::agr_cfg_t cfg_d;

   // gain one-hot; bypass relies on the host having set code 000
   assign cfg_d.gain_factor  = 8'h01 << gain_code;
   assign cfg_d.amp_enable   = (amp_code == agr_pkg::AMP_ENABLED);
   assign cfg_d.amp_bypass   = (amp_code == 2'b00);
   assign cfg_d.chop_enable  = rate_q[agr_pkg::RATE_CHOP_BIT];
   assign cfg_d.ext_clk_sel  = rate_q[agr_pkg::RATE_CLK_BIT];
   assign cfg_d.single_shot  = rate_q[agr_pkg::RATE_MODE_BIT];
   assign cfg_d.low_latency  = rate_q[agr_pkg::RATE_FILT_BIT];
   // rate field, codes above 1000 SPS flagged invalid
   assign cfg_d.rate_select  = rate_code;
   assign cfg_d.rate_valid   = (rate_code <= agr_pkg::RATE_CODE_MAX);
   assign cfg_d.mon_low_en   = (mon_code != 2'b00);
   assign cfg_d.mon_high_en  = (mon_code == 2'b10);
   assign cfg_d.mon_pull_en  = (mon_code == 2'b11);
   assign cfg_d.pos_buf_en   = !ref_q[agr_pkg::REF_PBUF_BIT];
   assign cfg_d.neg_buf_en   = !ref_q[agr_pkg::REF_NBUF_BIT];
   assign cfg_d.ref_source   = ref_q[agr_pkg::REF_SRC_LSB +: 2];
   assign cfg_d.int_ref_on   = (con_code == 2'b01) || (con_code == 2'b10);
   assign cfg_d.int_ref_keep = (con_code == 2'b10);

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_cfg     <= '0;
         o_rd_data <= 8'h00;
      end else if (i_ce) begin
         o_cfg     <= cfg_d;
         o_rd_data <= rd_d;
      end
   end

   // ---------------------------------------------------------------
   // Conversion delay after a configuration write
   // ---------------------------------------------------------------
   // A write reloads the counter even mid-delay, so the newest settings
   // always get the full settling time.
   agr_pkg::agr_dly_state_t state_q;
   logic [12:0]             cnt_q;
   wire [2:0] dly_code = wr_gain ? i_wr_data[agr_pkg::GAIN_DELAY_LSB +: 3]
                                 : gain_q[agr_pkg::GAIN_DELAY_LSB +: 3];
   wire       dly_done = (state_q == agr_pkg::DLY_WAIT) && i_mod_tick && (cnt_q == 13'd1);

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q      <= agr_pkg::DLY_IDLE;
         cnt_q        <= 13'd0;
         o_conv_start <= 1'b0;
         o_delay_busy <= 1'b0;
      end else if (i_ce) begin
         o_conv_start <= dly_done && !wr_any;
         if (wr_any) begin
            state_q      <= agr_pkg::DLY_WAIT;
            cnt_q        <= agr_pkg::delay_periods(dly_code);
            o_delay_busy <= 1'b1;
         end else if (dly_done) begin
            state_q      <= agr_pkg::DLY_IDLE;
            cnt_q        <= 13'd0;
            o_delay_busy <= 1'b0;
         end else if ((state_q == agr_pkg::DLY_WAIT) && i_mod_tick) begin
            cnt_q <= cnt_q - 13'd1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   dly_load_a: assert property (i_ce && wr_gain |=>
      cnt_q == agr_pkg::delay_periods($past(i_wr_data[7:5])))
      else $error("delay count not loaded from written code");
   busy_set_a: assert property (i_ce && wr_any |=> o_delay_busy && !o_conv_start)
      else $error("delay busy not raised by write");
   conv_start_a: assert property (i_ce && dly_done && !wr_any |=>
      o_conv_start && !o_delay_busy)
      else $error("conversion start missing after delay");
   amp_decode_a: assert property (i_ce |=>
      o_cfg.amp_enable == ($past(amp_code) == 2'b01) &&
      o_cfg.amp_bypass == ($past(amp_code) == 2'b00))
      else $error("amplifier enable decode wrong");
   gain_map_a: assert property (i_ce && wr_gain ##1 i_ce |=>
      o_cfg.gain_factor == (8'h01 << $past(i_wr_data[2:0], 2)))
      else $error("gain factor does not follow code");
   chop_follow_a: assert property (i_ce |=> o_cfg.chop_enable == $past(rate_q[7]))
      else $error("chop enable not following register");
   clk_select_a: assert property (i_ce && wr_rate ##1 i_ce |=>
      o_cfg.ext_clk_sel == $past(i_wr_data[6], 2))
      else $error("clock source select wrong");
   mode_bit_a: assert property (i_ce |=> o_cfg.single_shot == $past(rate_q[5]))
      else $error("conversion mode wrong");
   filter_bit_a: assert property (i_ce |=> o_cfg.low_latency == $past(rate_q[4]))
      else $error("filter select wrong");
   rate_sel_a: assert property (i_ce |=>
      o_cfg.rate_select == $past(rate_code) &&
      o_cfg.rate_valid == ($past(rate_code) < 4'hC))
      else $error("rate select wrong");
   mon_decode_a: assert property (i_ce |=>
      o_cfg.mon_high_en == ($past(mon_code) == 2'b10) &&
      o_cfg.mon_low_en == ($past(mon_code) != 2'b00) &&
      o_cfg.mon_pull_en == ($past(mon_code) == 2'b11))
      else $error("monitor decode wrong");
   ref_src_a: assert property (i_ce |=> o_cfg.ref_source == $past(ref_q[3:2]))
      else $error("reference source wrong");
   int_ref_a: assert property (i_ce |=>
      o_cfg.int_ref_keep == ($past(con_code) == 2'b10) &&
      o_cfg.int_ref_on == ($past(con_code) inside {2'b01, 2'b10}))
      else $error("internal reference decode wrong");

   wr_gain_c: cover property (i_ce && wr_gain ##1 i_ce ##1 o_cfg.amp_enable);
   start_c:   cover property (o_delay_busy ##[1:40] o_conv_start);
   chop_c:    cover property (o_cfg.chop_enable && o_cfg.single_shot);

endmodule // agr_config_bank

`default_nettype wire

// File: logic/agr_pkg.sv
// Package for the converter configuration bank: register offsets, field
// positions, reset values, decoded configuration carrier.
// Assumes a single 100 MHz clock domain and 8-bit register words.
`default_nettype none

package agr_pkg;

   // ------------------------------------------------------------------
   // Register offsets and reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_AMPLIFIER_GAIN_CONFIG  = 8'h03;
   localparam logic [7:0] OFS_CONVERSION_RATE_CONFIG = 8'h04;
   localparam logic [7:0] OFS_REFERENCE_CONFIG       = 8'h05;
   localparam logic [7:0] RST_AMPLIFIER_GAIN_CONFIG  = 8'h00;
   localparam logic [7:0] RST_CONVERSION_RATE_CONFIG = 8'h14;
   localparam logic [7:0] RST_REFERENCE_CONFIG       = 8'h10;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int GAIN_DELAY_LSB = 5;
   localparam int GAIN_AMP_LSB   = 3;
   localparam int GAIN_CODE_LSB  = 0;
   localparam int RATE_CHOP_BIT  = 7;
   localparam int RATE_CLK_BIT   = 6;
   localparam int RATE_MODE_BIT  = 5;
   localparam int RATE_FILT_BIT  = 4;
   localparam int RATE_SEL_LSB   = 0;
   localparam int REF_MON_LSB    = 6;
   localparam int REF_PBUF_BIT   = 5;
   localparam int REF_NBUF_BIT   = 4;
   localparam int REF_SRC_LSB    = 2;
   localparam int REF_CON_LSB    = 0;

   // ------------------------------------------------------------------
   // Codes and timing counts, in modulator periods
   // ------------------------------------------------------------------
   localparam logic [1:0]  AMP_ENABLED    = 2'b01;
   localparam logic [3:0]  RATE_CODE_MAX  = 4'hB;
   localparam logic [12:0] DLY_MOD_0      = 13'd14;
   localparam logic [12:0] DLY_MOD_1      = 13'd25;
   localparam logic [12:0] DLY_MOD_2      = 13'd64;
   localparam logic [12:0] DLY_MOD_3      = 13'd256;
   localparam logic [12:0] DLY_MOD_4      = 13'd1024;
   localparam logic [12:0] DLY_MOD_5      = 13'd2048;
   localparam logic [12:0] DLY_MOD_6      = 13'd4096;

   typedef enum logic [0:0] {
      DLY_IDLE = 1'b0,
      DLY_WAIT = 1'b1
   } agr_dly_state_t;

   // Decoded configuration handed to the analog and filter logic
   typedef struct packed {
      logic [7:0] gain_factor;    // One-hot: bit n means gain 2**n
      logic       amp_enable;
      logic       amp_bypass;
      logic       chop_enable;
      logic       ext_clk_sel;
      logic       single_shot;
      logic       low_latency;
      logic [3:0] rate_select;
      logic       rate_valid;
      logic       mon_low_en;
      logic       mon_high_en;
      logic       mon_pull_en;
      logic       pos_buf_en;
      logic       neg_buf_en;
      logic [1:0] ref_source;
      logic       int_ref_on;
      logic       int_ref_keep;   // Stays on in power-down
   } agr_cfg_t;

   // Conversion delay in modulator periods for a delay code
   function automatic logic [12:0] delay_periods(input logic [2:0] code);
      logic [12:0] r;
      r = DLY_MOD_0;
      unique case (code)
         3'd0: r = DLY_MOD_0;
         3'd1: r = DLY_MOD_1;
         3'd2: r = DLY_MOD_2;
         3'd3: r = DLY_MOD_3;
         3'd4: r = DLY_MOD_4;
         3'd5: r = DLY_MOD_5;
         3'd6: r = DLY_MOD_6;
         3'd7: r = DLY_MOD_0;
      endcase
      return r;
   endfunction

endpackage

`default_nettype wire

// File: verification/test_agr_config_bank.sv
// Testbench for the converter configuration bank: register writes and reads,
// decoded configuration, conversion delay, restart and clock-enable freeze.
// Assumes the bank alone, driven directly; the modulator tick is made here.
`timescale 1ns/1ns
`default_nettype none

module test_agr_config_bank;
   logic              i_clk      = 1'b0;
   logic              i_arst_n   = 1'b0;
   logic              i_ce       = 1'b1;
   logic              i_wr_valid = 1'b0;
   logic [7:0]        i_wr_addr  = 8'h00;
   logic [7:0]        i_wr_data  = 8'h00;
   logic [7:0]        i_rd_addr  = 8'h00;
   logic              i_mod_tick = 1'b0;
   logic [7:0]        o_rd_data;
   agr_pkg::agr_cfg_t o_cfg;
   logic              o_delay_busy;
   logic              o_conv_start;
   logic              tick_all   = 1'b0;
   logic [7:0]        rg [3];
   logic [7:0]        d;
   logic [1:0]        a2;
   int                errors     = 0;
   int                n_tests    = 0;
   int                nt [5]     = '{14, 25, 64, 256, 1024};
   int                n;
   int                k;

   always #5 i_clk = ~i_clk;
   // Random ticks before the delay tests; held high from then on
   always @(posedge i_clk) i_mod_tick <= tick_all | ($urandom % 2 == 1);

   agr_config_bank dut (
      .i_clk        (i_clk),
      .i_arst_n     (i_arst_n),
      .i_ce         (i_ce),
      .i_wr_valid   (i_wr_valid),
      .i_wr_addr    (i_wr_addr),
      .i_wr_data    (i_wr_data),
      .i_rd_addr    (i_rd_addr),
      .i_mod_tick   (i_mod_tick),
      .o_rd_data    (o_rd_data),
      .o_cfg        (o_cfg),
      .o_delay_busy (o_delay_busy),
      .o_conv_start (o_conv_start)
   );

   // ------------------------------------------------------------------
   // Checking helpers
   // ------------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (e !== g) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   function automatic agr_pkg::agr_cfg_t exp_cfg(input logic [7:0] g, input logic [7:0] r,
                                                 input logic [7:0] f);
      agr_pkg::agr_cfg_t c;
      c.gain_factor  = 8'h01 << g[2:0];
      c.amp_enable   = g[4:3] == 2'b01;
      c.amp_bypass   = g[4:3] == 2'b00;
      c.chop_enable  = r[7];
      c.ext_clk_sel  = r[6];
      c.single_shot  = r[5];
      c.low_latency  = r[4];
      c.rate_select  = r[3:0];
      c.rate_valid   = r[3:0] <= 4'hb;
      c.mon_low_en   = f[7:6] != 2'b00;
      c.mon_high_en  = f[7:6] == 2'b10;
      c.mon_pull_en  = f[7:6] == 2'b11;
      c.pos_buf_en   = ~f[5];
      c.neg_buf_en   = ~f[4];
      c.ref_source   = f[3:2];
      c.int_ref_on   = f[1:0] != 2'b00;
      c.int_ref_keep = f[1:0] == 2'b10;
      return c;
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic ce);
      @(posedge i_clk);
      i_wr_valid <= 1'b1;
      i_wr_addr  <= a;
      i_wr_data  <= v;
      i_ce       <= ce;
      @(posedge i_clk);
      i_wr_valid <= 1'b0;
      if (ce && a >= 8'h03 && a <= 8'h05) rg[a - 8'h03] = v;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge i_clk);
      i_rd_addr <= a;
      i_ce      <= 1'b1;
      @(posedge i_clk);
      #1 chk("rd_data", (a >= 8'h03 && a <= 8'h05) ? rg[a - 8'h03] : 8'h00, o_rd_data);
   endtask

   // Edges from the edge that takes the write to the start pulse: the count,
   // since ticks seen in the write cycle itself are not counted
   task automatic delay(input int nexp);
      #1 n = 0;
      while (o_conv_start !== 1'b1 && n < 5000) begin
         @(posedge i_clk);
         #1 n++;
         if (n == 1) chk("delay_busy", 1, o_delay_busy);
      end
      chk("delay_edges", nexp, n);
      chk("busy_at_start", 0, o_delay_busy);
      @(posedge i_clk);
      #1 chk("start_pulse", 0, {o_conv_start, o_delay_busy});
   endtask

   task automatic summarize;
      if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      void'($urandom(30));
      repeat (10) @(posedge i_clk);
      chk("cfg_in_reset", 0, o_cfg);
      i_arst_n <= 1'b1;
      rg[0] = agr_pkg::RST_AMPLIFIER_GAIN_CONFIG;
      rg[1] = agr_pkg::RST_CONVERSION_RATE_CONFIG;
      rg[2] = agr_pkg::RST_REFERENCE_CONFIG;
      for (int a = 2; a < 8; a++) rd(8'(a));
      rd(8'hff);
      chk("cfg", exp_cfg(rg[0], rg[1], rg[2]), o_cfg);
      // Only legal codes; gain kept at 000 under bypass
      for (int i = 0; i < 60; i++) begin
         k  = $urandom % 3;
         a2 = 2'($urandom % 2);
         if (k == 0) d = {3'($urandom % 5), a2, a2[0] ? 3'($urandom) : 3'b000};
         else if (k == 1) d = {4'($urandom), 4'($urandom % 12)};
         else d = {4'($urandom), 2'($urandom % 3), 2'($urandom % 3)};
         wr(8'h03 + 8'(k), d, ($urandom % 4) != 0);
         rd(8'h03 + 8'($urandom % 3));
         chk("cfg", exp_cfg(rg[0], rg[1], rg[2]), o_cfg);
      end
      tick_all = 1'b1;
      for (int c = 0; c < 5; c++) begin
         wr(8'h03, {3'(c), 5'b0_1111}, 1'b1);
         delay(nt[c]);
      end
      chk("cfg", exp_cfg(rg[0], rg[1], rg[2]), o_cfg);
      // A second write during the delay restarts it with the stored code
      wr(8'h03, 8'h28, 1'b1);
      repeat (10) @(posedge i_clk);
      wr(8'h04, rg[1], 1'b1);
      delay(nt[1]);
      summarize;
   end

   initial begin
      #200000;
      errors++;
      summarize;
   end
endmodule // test_agr_config_bank

`default_nettype wire
